// ### rtl/ast_top.sv
// full-duplex asynchronous serial transceiver core
module ast_top
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // serial pins
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  // frame and enable controls
  input wire logic NINE_BIT_SELECT,
  input wire logic TX_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic SEND_BREAK,
  input wire logic WAKE_METHOD,
  input wire logic RX_MUTE_SET,
  // interrupt controls
  input wire logic TX_EMPTY_INT_ENABLE,
  input wire logic TX_DONE_INT_ENABLE,
  input wire logic RX_INT_ENABLE,
  input wire logic IDLE_INT_ENABLE,
  input wire logic GLOBAL_INT_MASK,
  // rate controls
  input wire logic [1:0] COARSE_DIVIDER_SEL,
  input wire logic [2:0] TX_RATE_SEL,
  input wire logic [2:0] RX_RATE_SEL,
  input wire logic [7:0] TX_FINE_DIVIDER,
  input wire logic [7:0] RX_FINE_DIVIDER,
  // register access strobes
  input wire logic STATUS_ACCESS,
  input wire logic DATA_READ,
  // transmit data
  input wire logic TX_WVALID,
  output logic TX_WREADY,
  input wire logic [7:0] TX_WDATA,
  input wire logic TX_NINTH_BIT,
  // receive data and status
  output logic [7:0] RX_DATA,
  output logic RX_NINTH_BIT,
  output logic RX_FULL_FLAG,
  output logic RX_OVERRUN_FLAG,
  output logic NOISE_FLAG,
  output logic FRAMING_ERROR_FLAG,
  output logic IDLE_FLAG,
  output logic RX_MUTE,
  output logic TX_EMPTY_FLAG,
  output logic TX_DONE_FLAG,
  output logic IRQ
);
  // baud ticks
  logic tx_os_tick; // transmit oversample tick
  logic rx_os_tick; // receive oversample tick
  // transmit side
  ast_pkg::ast_tx_e tx_st_q, tx_st_d;
  logic [3:0] tx_os_q; // oversample count within a bit
  logic tx_bit_tick; // bit boundary
  logic [10:0] tx_sh_q, tx_sh_d; // remaining frame bits
  logic [3:0] tx_left_q, tx_left_d; // bits left in frame
  logic tx_line_q; // registered pin level
  logic te_q; // previous enable
  logic te_rise; // enable rising edge
  logic idle_req_q, idle_req_d; // idle frame owed
  logic brk_tail_q, brk_tail_d; // high bit owed after break
  logic tx_pop; // take a word from the buffer
  logic tx_end; // frame finished with nothing after it
  logic buf_valid; // buffer holds a word
  logic [8:0] buf_data; // word at the buffer head
  logic [3:0] frame_bits; // bits per frame for the word size
  // register access sequencing
  logic seq_arm_q; // status access seen
  logic wr_take; // data write accepted
  logic clr_rx; // read half of the sequence
  logic clr_tx; // write half of the sequence
  // receive side
  logic rx_m_q, rx_s_q; // pin synchroniser
  ast_pkg::ast_rx_e rx_st_q;
  logic [2:0] hist_q; // last three line samples, shifted in every state
  logic [3:0] rx_os_q; // oversample number of next tick
  logic [3:0] rx_bit_q; // data bit index
  logic [8:0] rx_sh_q; // receive shift register
  logic [2:0] mid_q; // middle samples
  logic edge_bad_q; // start edge failed its checks
  logic frm_noise_q; // noise within frame
  logic noise_pend_q; // noise kept from a false start
  logic [7:0] idle_cnt_q; // high oversamples while hunting
  logic idle_arm_q; // idle detection allowed
  logic maj; // majority of middle samples
  logic disagree; // middle samples disagree
  logic char_ev_q; // character complete pulse
  logic idle_ev_q; // idle frame pulse
  logic [8:0] ev_data_q; // completed word
  logic ev_fe_q; // stop bit missing
  logic ev_noise_q; // noise for the completed word
  logic addr_mark; // msb of the completed word
  logic deliver; // completed word reaches software

  // rate generators, one per direction
  ast_baud u_tx_baud
  (
    .clk(MCLK),
    .rst(SYS_RST),
    .coarse_sel(COARSE_DIVIDER_SEL),
    .rate_sel(TX_RATE_SEL),
    .fine_div(TX_FINE_DIVIDER),
    .os_tick(tx_os_tick)
  );
  ast_baud u_rx_baud
  (
    .clk(MCLK),
    .rst(SYS_RST),
    .coarse_sel(COARSE_DIVIDER_SEL),
    .rate_sel(RX_RATE_SEL),
    .fine_div(RX_FINE_DIVIDER),
    .os_tick(rx_os_tick)
  );

  // transmit holding buffer, flushed when the enable is re-asserted
  ast_buf #(.WIDTH(9)) u_tx_buf
  (
    .clk(MCLK),
    .rst(SYS_RST),
    .flush(te_rise), // RULE4
    .in_valid(TX_WVALID),
    .in_ready(TX_WREADY),
    .in_data({TX_NINTH_BIT, TX_WDATA}),
    .out_valid(buf_valid),
    .out_ready(tx_pop),
    .out_data(buf_data)
  );

  assign te_rise = TX_ENABLE && !te_q;
  assign tx_bit_tick = tx_os_tick && (tx_os_q == ast_pkg::OS_LAST);
  assign frame_bits = NINE_BIT_SELECT ? ast_pkg::FRAME_BITS_9
                                      : ast_pkg::FRAME_BITS_8;
  assign wr_take = TX_WVALID && TX_WREADY;
  assign clr_rx = DATA_READ && seq_arm_q;
  assign clr_tx = wr_take && seq_arm_q;
  assign SERIAL_OUT_PIN = tx_line_q;

  // transmit bit timing: sixteen oversample ticks per bit
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_os_q <= 4'h0;
      te_q <= 1'b0;
    end
    else
    begin
      te_q <= TX_ENABLE;
      if (tx_os_tick)
        tx_os_q <= tx_os_q + 4'h1;
    end
  end

  // transmitter next state: frames start only on bit boundaries
  always_comb
  begin
    logic start;
    start = 1'b0;
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    idle_req_d = idle_req_q || te_rise; // RULE3 RULE4
    brk_tail_d = brk_tail_q;
    tx_pop = 1'b0;
    tx_end = 1'b0;
    unique case (tx_st_q)
      ast_pkg::TX_OFF:
      begin
        if (TX_ENABLE)
          tx_st_d = ast_pkg::TX_READY;
      end
      ast_pkg::TX_READY:
      begin
        start = tx_bit_tick;
      end
      ast_pkg::TX_SEND:
      begin
        if (tx_bit_tick && tx_left_q == 4'h1)
          start = 1'b1;
        else if (tx_bit_tick)
        begin
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          tx_left_d = tx_left_q - 4'h1;
        end
      end
    endcase
    if (start)
    begin
      tx_st_d = ast_pkg::TX_SEND;
      if (!TX_ENABLE)
        tx_st_d = ast_pkg::TX_OFF;
      else if (SEND_BREAK)
      begin
        // break frame: all low, length from word size
        tx_sh_d = 11'h000; // RULE2
        tx_left_d = frame_bits;
        brk_tail_d = 1'b1;
      end
      else if (brk_tail_q)
      begin
        // one high bit after the last break frame
        tx_sh_d = 11'h7FF; // RULE2
        tx_left_d = 4'h1;
        brk_tail_d = 1'b0;
      end
      else if (idle_req_q)
      begin
        // idle frame: all high
        tx_sh_d = 11'h7FF; // RULE3 RULE4
        tx_left_d = frame_bits;
        idle_req_d = te_rise;
      end
      else if (buf_valid)
      begin
        // data frame: start low, lsb first, stop high
        tx_sh_d = NINE_BIT_SELECT ? {1'b1, buf_data, 1'b0} // RULE23
                                  : {2'b11, buf_data[7:0], 1'b0};
        tx_left_d = frame_bits;
        tx_pop = 1'b1;
      end
      else
        tx_st_d = ast_pkg::TX_READY;
      tx_end = (tx_st_q == ast_pkg::TX_SEND) &&
               (tx_st_d != ast_pkg::TX_SEND);
    end
  end

  // transmitter state and registered pin, high whenever not sending
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_st_q <= ast_pkg::TX_OFF;
      tx_sh_q <= 11'h7FF;
      tx_left_q <= 4'h0;
      idle_req_q <= 1'b0;
      brk_tail_q <= 1'b0;
      tx_line_q <= 1'b1;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      idle_req_q <= idle_req_d;
      brk_tail_q <= brk_tail_d;
      tx_line_q <= (tx_st_d == ast_pkg::TX_SEND) ? tx_sh_d[0] : 1'b1; // RULE23
    end
  end

  // status-then-data sequence and transmit flags; hardware set wins
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      seq_arm_q <= 1'b0;
      TX_EMPTY_FLAG <= ast_pkg::TX_EMPTY_RST;
      TX_DONE_FLAG <= ast_pkg::TX_DONE_RST;
    end
    else
    begin
      if (STATUS_ACCESS)
        seq_arm_q <= 1'b1;
      else if (DATA_READ || wr_take)
        seq_arm_q <= 1'b0;
      TX_EMPTY_FLAG <= (TX_EMPTY_FLAG && !clr_tx) || tx_pop; // RULE1
      TX_DONE_FLAG <= (TX_DONE_FLAG && !clr_tx) || tx_end; // RULE1
    end
  end

  // receive pin synchroniser
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end
    else
    begin
      rx_m_q <= SERIAL_IN_PIN;
      rx_s_q <= rx_m_q;
    end
  end

  assign maj = (mid_q[0] & mid_q[1]) | (mid_q[0] & mid_q[2]) |
               (mid_q[1] & mid_q[2]); // RULE24
  assign disagree = (mid_q != 3'b000) && (mid_q != 3'b111); // RULE13

  // receiver: hunt, start check, data bits, stop bit
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_st_q <= ast_pkg::RX_HUNT;
      hist_q <= 3'b000;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      mid_q <= 3'b000;
      edge_bad_q <= 1'b0;
      frm_noise_q <= 1'b0;
      noise_pend_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      idle_arm_q <= 1'b1; // line counts as idle-owed, like a fresh enable
      char_ev_q <= 1'b0;
      idle_ev_q <= 1'b0;
      ev_data_q <= 9'h000;
      ev_fe_q <= 1'b0;
      ev_noise_q <= 1'b0;
    end
    else
    begin
      char_ev_q <= 1'b0;
      idle_ev_q <= 1'b0;
      if (!RX_ENABLE)
      begin
        // disabled: park and allow an idle after enabling
        rx_st_q <= ast_pkg::RX_HUNT;
        hist_q <= 3'b000;
        idle_cnt_q <= 8'h00;
        idle_arm_q <= 1'b1;
      end
      else if (rx_os_tick)
      begin
        hist_q <= {hist_q[1:0], rx_s_q};
        if (rx_st_q == ast_pkg::RX_HUNT)
        begin
          // falling edge after three highs starts a frame
          if (hist_q == 3'b111 && !rx_s_q) // RULE7
          begin
            rx_st_q <= ast_pkg::RX_START;
            rx_os_q <= ast_pkg::AFTER_EDGE; // RULE25
            edge_bad_q <= 1'b0;
            frm_noise_q <= 1'b0;
            rx_bit_q <= 4'h0;
          end
          // a whole frame of highs is an idle frame
          if (!rx_s_q)
            idle_cnt_q <= 8'h00;
          else if (idle_cnt_q != 8'hFF)
            idle_cnt_q <= idle_cnt_q + 8'h01;
          if (rx_s_q && idle_arm_q && idle_cnt_q ==
              (NINE_BIT_SELECT ? ast_pkg::IDLE_OS_9 : ast_pkg::IDLE_OS_8)
              - 8'h01)
          begin
            idle_ev_q <= 1'b1; // RULE12
            idle_arm_q <= 1'b0;
          end
        end
        else
        begin
          rx_os_q <= rx_os_q + 4'h1;
          // start bit edge checks on samples 3, 5 and 7
          if (rx_st_q == ast_pkg::RX_START && rx_s_q &&
              (rx_os_q == ast_pkg::EDGE_CHK_A ||
               rx_os_q == ast_pkg::EDGE_CHK_B ||
               rx_os_q == ast_pkg::EDGE_CHK_C))
            edge_bad_q <= 1'b1; // RULE13
          // middle samples 8, 9 and 10
          if (rx_os_q >= ast_pkg::MID_FIRST && rx_os_q <= ast_pkg::MID_LAST)
            mid_q <= {mid_q[1:0], rx_s_q}; // RULE24
          if (rx_os_q == ast_pkg::BIT_END)
          begin
            unique case (rx_st_q)
              ast_pkg::RX_START:
              begin
                if (maj)
                begin
                  // false start: drop frame, remember noise
                  rx_st_q <= ast_pkg::RX_HUNT; // RULE15
                  noise_pend_q <= 1'b1; // RULE15
                end
                else
                begin
                  frm_noise_q <= disagree || edge_bad_q; // RULE13
                  rx_st_q <= ast_pkg::RX_DATA;
                end
              end
              ast_pkg::RX_DATA:
              begin
                rx_sh_q[rx_bit_q] <= maj; // RULE6
                frm_noise_q <= frm_noise_q || disagree; // RULE13
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == (NINE_BIT_SELECT ? ast_pkg::DATA_LAST_9
                                                 : ast_pkg::DATA_LAST_8))
                  rx_st_q <= ast_pkg::RX_STOP; // RULE5
              end
              ast_pkg::RX_STOP:
              begin
                // low stop bit (also a break) is a framing error
                char_ev_q <= 1'b1;
                ev_fe_q <= !maj; // RULE11 RULE16
                ev_noise_q <= frm_noise_q || disagree || noise_pend_q;
                ev_data_q <= NINE_BIT_SELECT ? rx_sh_q
                                             : {1'b0, rx_sh_q[7:0]};
                noise_pend_q <= 1'b0;
                rx_st_q <= ast_pkg::RX_HUNT;
                idle_cnt_q <= 8'h00;
                idle_arm_q <= 1'b1;
              end
              default:
                rx_st_q <= ast_pkg::RX_HUNT;
            endcase
          end
        end
      end
    end
  end

  assign addr_mark = NINE_BIT_SELECT ? ev_data_q[8] : ev_data_q[7];
  assign deliver = char_ev_q && (!RX_MUTE || (WAKE_METHOD && addr_mark));

  // receive flags, holding buffer and mute; hardware set wins
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RX_DATA <= 8'h00;
      RX_NINTH_BIT <= 1'b0;
      RX_FULL_FLAG <= 1'b0;
      RX_OVERRUN_FLAG <= 1'b0;
      NOISE_FLAG <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
      IDLE_FLAG <= 1'b0;
      RX_MUTE <= 1'b0;
    end
    else
    begin
      RX_FULL_FLAG <= RX_FULL_FLAG && !clr_rx; // RULE9
      RX_OVERRUN_FLAG <= RX_OVERRUN_FLAG && !clr_rx; // RULE10
      NOISE_FLAG <= NOISE_FLAG && !clr_rx; // RULE14
      FRAMING_ERROR_FLAG <= FRAMING_ERROR_FLAG && !clr_rx; // RULE16
      IDLE_FLAG <= IDLE_FLAG && !clr_rx;
      if (RX_MUTE_SET)
        RX_MUTE <= 1'b1;
      else if (char_ev_q && RX_MUTE && WAKE_METHOD && addr_mark)
        RX_MUTE <= 1'b0; // RULE22
      else if (idle_ev_q && RX_MUTE && !WAKE_METHOD)
        RX_MUTE <= 1'b0; // RULE21
      if (deliver) // RULE20
      begin
        if (RX_FULL_FLAG && !clr_rx)
          RX_OVERRUN_FLAG <= 1'b1; // RULE10
        else
        begin
          RX_DATA <= ev_data_q[7:0]; // RULE8
          RX_NINTH_BIT <= ev_data_q[8]; // RULE5
          RX_FULL_FLAG <= 1'b1; // RULE8 RULE22
          NOISE_FLAG <= ev_noise_q; // RULE14
          FRAMING_ERROR_FLAG <= ev_fe_q; // RULE16
        end
      end
      if (idle_ev_q && !RX_MUTE)
        IDLE_FLAG <= 1'b1; // RULE12 RULE20
    end
  end

  // single interrupt request, gated by the global mask
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      IRQ <= 1'b0;
    else
      IRQ <= !GLOBAL_INT_MASK &&
             ((TX_EMPTY_FLAG && TX_EMPTY_INT_ENABLE) ||
              (TX_DONE_FLAG && TX_DONE_INT_ENABLE) ||
              ((RX_FULL_FLAG || RX_OVERRUN_FLAG) && RX_INT_ENABLE) || // RULE8
              (IDLE_FLAG && IDLE_INT_ENABLE)); // RULE12
  end
endmodule

// ### include/ast_pkg.sv
// constants, encodings and helpers shared by the serial transceiver
// Functional notes
// (RULE1) status access then data write clears tx flags
// (RULE2) break frames repeat, then one high bit
// (RULE3) enabling transmitter sends one idle frame first
// (RULE4) re-enabling transmitter: idle frame, buffer discarded
// (RULE5) receive 8 or 9 bits, ninth kept
// (RULE6) receive lsb first into holding buffer
// (RULE7) receiver enable starts start-bit hunt
// (RULE8) completed character loads buffer, sets full, interrupts
// (RULE9) status then data read clears full
// (RULE10) overrun keeps buffer, sets flag, interrupts
// (RULE11) received break counts as framing error
// (RULE12) idle frame sets idle flag, optional interrupt
// (RULE13) three middle samples must agree, else noise
// (RULE14) noise rises with full, no own interrupt
// (RULE15) false start discarded, noise shown next frame
// (RULE16) missing stop bit sets framing error
// (RULE17) rate is clock over 16, coarse, power-of-two
// (RULE18) software keeps dividers still while enabled
// (RULE19) nonzero fine divider further divides rate
// (RULE20) muted receiver sets no flags, no interrupts
// (RULE21) idle wake clears mute, no idle flag
// (RULE22) address mark wake clears mute, sets full
// (RULE23) start low, stop high, idle line high
// (RULE24) sixteen oversamples, majority of middle three
// (RULE25) oversample counter restarts on each start edge
package ast_pkg;
  // oversample numbers inside one bit time (1..16, 16 wraps to 0)
  localparam logic [3:0] EDGE_CHK_A = 4'h3;
  localparam logic [3:0] EDGE_CHK_B = 4'h5;
  localparam logic [3:0] EDGE_CHK_C = 4'h7;
  localparam logic [3:0] MID_FIRST = 4'h8;
  localparam logic [3:0] MID_LAST = 4'hA;
  localparam logic [3:0] BIT_END = 4'h0;
  localparam logic [3:0] AFTER_EDGE = 4'h2;
  localparam logic [3:0] OS_LAST = 4'hF;
  // frame lengths in bits (start + data + stop)
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] DATA_LAST_8 = 4'h7;
  localparam logic [3:0] DATA_LAST_9 = 4'h8;
  // idle frame length in oversamples
  localparam logic [7:0] IDLE_OS_8 = 8'hA0;
  localparam logic [7:0] IDLE_OS_9 = 8'hB0;
  // status reset values
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam logic TX_DONE_RST = 1'b1;
  // width of the baud divider counter
  localparam int BAUD_W = 19;
  // coarse divider factors 1, 3, 4, 13
  localparam logic [4:0] COARSE_1 = 5'h01;
  localparam logic [4:0] COARSE_3 = 5'h03;
  localparam logic [4:0] COARSE_4 = 5'h04;
  localparam logic [4:0] COARSE_13 = 5'h0D;

  // transmitter states
  typedef enum logic [1:0]
  {
    TX_OFF = 2'b00,
    TX_READY = 2'b01,
    TX_SEND = 2'b10
  } ast_tx_e;

  // receiver states
  typedef enum logic [1:0]
  {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } ast_rx_e;

  // map the coarse select code to its factor
  function automatic logic [4:0] coarse_factor(input logic [1:0] sel);
    logic [4:0] f;
    f = COARSE_1;
    unique case (sel)
      2'b00: f = COARSE_1;
      2'b01: f = COARSE_3;
      2'b10: f = COARSE_4;
      2'b11: f = COARSE_13;
    endcase
    return f;
  endfunction
endpackage

// ### rtl/ast_baud.sv
// oversample tick generator: clock / (coarse * 2^sel * fine)
module ast_baud
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // divider settings
  input wire logic [1:0] coarse_sel,
  input wire logic [2:0] rate_sel,
  input wire logic [7:0] fine_div,
  // one-cycle pulse per oversample period
  output logic os_tick
);
  localparam int W = ast_pkg::BAUD_W;
  logic [W-1:0] cnt_q; // period counter
  logic [W-1:0] limit; // period minus one
  logic [W-1:0] base; // coarse times power of two

  // period from the three divider stages, fine zero means bypass
  always_comb
  begin
    base = W'(ast_pkg::coarse_factor(coarse_sel)) << rate_sel; // RULE17
    if (fine_div != 8'h00)
      limit = W'(base * W'(fine_div)) - W'(1); // RULE19
    else
      limit = base - W'(1);
  end

  // free-running counter, restarts at the limit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      os_tick <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q <= '0;
      os_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
      os_tick <= 1'b0;
    end
  end
endmodule

// ### rtl/ast_buf.sv
// two-entry valid/ready buffer with flush
module ast_buf
#(
  parameter int WIDTH = 9
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2]; // storage
  logic rd_q; // read slot
  logic wr_q; // write slot
  logic [1:0] cnt_q; // occupancy
  logic push;
  logic pop;

  // refuse a width the storage cannot hold
  if (WIDTH < 1)
  begin
    $error("ast_buf: WIDTH must be at least 1");
  end

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers and occupancy; flush empties both entries
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else if (flush)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // entry storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule

// ### tb/ast_chk.sv
// assertions on the transceiver top ports
module ast_chk
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // watched ports
  input wire logic SERIAL_OUT_PIN,
  input wire logic WAKE_METHOD,
  input wire logic RX_INT_ENABLE,
  input wire logic GLOBAL_INT_MASK,
  input wire logic DATA_READ,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_FULL_FLAG,
  input wire logic NOISE_FLAG,
  input wire logic FRAMING_ERROR_FLAG,
  input wire logic IDLE_FLAG,
  input wire logic RX_MUTE,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  // eight low samples of the line
  sequence s_low8;
    !SERIAL_OUT_PIN [*8];
  endsequence
  // any low bit lasts at least sixteen clocks
  AST_BIT_LEN:
    assert property ($fell(SERIAL_OUT_PIN) |-> s_low8 ##1 s_low8)
    else $error("low bit too short");
  // a held word is kept until read
  AST_HOLD:
    assert property (RX_FULL_FLAG && !DATA_READ |=> $stable(RX_DATA))
    else $error("held word changed");
  AST_NOISE_FULL:
    assert property ($rose(NOISE_FLAG) |-> RX_FULL_FLAG)
    else $error("noise without full");
  AST_FE_FULL:
    assert property ($rose(FRAMING_ERROR_FLAG) |-> RX_FULL_FLAG)
    else $error("framing without full");
  // a muted receiver raises no full, idle or noise flag
  AST_MUTE:
    assert property (RX_MUTE ##1 RX_MUTE |-> !$rose(RX_FULL_FLAG)
      && !$rose(IDLE_FLAG) && !$rose(NOISE_FLAG))
    else $error("flag while muted");
  AST_WAKE:
    assert property ($fell(RX_MUTE) && WAKE_METHOD |-> ##[0:2] RX_FULL_FLAG)
    else $error("wake without full");
  AST_MASK:
    assert property (GLOBAL_INT_MASK |=> !IRQ)
    else $error("masked interrupt");
  AST_IRQ:
    assert property (RX_FULL_FLAG && RX_INT_ENABLE && !GLOBAL_INT_MASK
      |=> IRQ)
    else $error("missing interrupt");
endmodule

// ### tb/ast_peer.sv
// far-side serial device: sends frames, captures the device's frames
module ast_peer
(
  // clock
  input wire logic clk,
  // serial lines
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int bt = 64;  // bit time in clocks
  logic [8:0] cap;  // stop bit and data
  logic [8:0] got_q[$];  // captured frames
  // the line idles high
  initial line_out = 1'b1;
  // md: 0 clean, 1 stop low, 2 noisy bit 3, 3 short start
  task automatic send(input logic [8:0] w, input int nb, input int md);
    int i;
    @(negedge clk) line_out = 1'b0;
    repeat (md == 3 ? 24 : bt) @(negedge clk);
    for (i = 0; i < nb && md != 3; i++)
    begin
      line_out = w[i];
      repeat (md == 2 && i == 3 ? 35 : bt) @(negedge clk);
      if (md == 2 && i == 3)
      begin
        line_out = ~w[i];  // one sample flipped
        repeat (4) @(negedge clk);
        line_out = w[i];
        repeat (bt - 39) @(negedge clk);
      end
    end
    line_out = md != 1;  // stop bit
    repeat (md == 3 ? 0 : bt) @(negedge clk);
    line_out = 1'b1;
    repeat (bt) @(negedge clk);
  endtask
  // capture mid-bit, lsb first, stop bit on top
  initial
    forever
    begin
      @(negedge line_in);
      repeat (bt / 2) @(posedge clk);
      for (int j = 0; j < 9; j++)
      begin
        repeat (bt) @(posedge clk);
        cap[j] = line_in;
      end
      got_q.push_back(cap);
    end
endmodule

// ### tb/ast_tb_top.sv
// bench top: drives the transceiver and checks it
module ast_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK, SYS_RST, SERIAL_IN_PIN, NINE_BIT_SELECT, TX_ENABLE;
  logic RX_ENABLE, SEND_BREAK, WAKE_METHOD, RX_MUTE_SET, TX_NINTH_BIT;
  logic TX_EMPTY_INT_ENABLE, TX_DONE_INT_ENABLE, RX_INT_ENABLE;
  logic IDLE_INT_ENABLE, GLOBAL_INT_MASK, STATUS_ACCESS, DATA_READ;
  logic [1:0] COARSE_DIVIDER_SEL;
  logic [2:0] TX_RATE_SEL, RX_RATE_SEL;
  logic [7:0] TX_FINE_DIVIDER, RX_FINE_DIVIDER, TX_WDATA, RX_DATA, seed;
  logic SERIAL_OUT_PIN, TX_WREADY, TX_WVALID, RX_NINTH_BIT, RX_FULL_FLAG;
  logic RX_OVERRUN_FLAG, NOISE_FLAG, FRAMING_ERROR_FLAG, IDLE_FLAG;
  logic RX_MUTE, TX_EMPTY_FLAG, TX_DONE_FLAG, IRQ;
  logic [8:0] exq[$];  // frames the far side should see
  int errors, compares, k, n;
  ast_top dut (.*);
  ast_peer u_peer (.clk(MCLK), .line_in(SERIAL_OUT_PIN),
    .line_out(SERIAL_IN_PIN));
  // 100 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // lfsr step for data words
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  // full, overrun, noise, framing
  task flags(input logic [8:0] e);
    chk({RX_FULL_FLAG, RX_OVERRUN_FLAG, NOISE_FLAG, FRAMING_ERROR_FLAG}, e);
  endtask
  task sa;
    @(negedge MCLK) STATUS_ACCESS = 1'b1;
    @(negedge MCLK) STATUS_ACCESS = 1'b0;
  endtask
  // status access then data read
  task clr;
    sa;
    DATA_READ = 1'b1;
    @(negedge MCLK) DATA_READ = 1'b0;
    @(negedge MCLK);
  endtask
  task mute;
    @(negedge MCLK) RX_MUTE_SET = 1'b1;
    @(negedge MCLK) RX_MUTE_SET = 1'b0;
    chk(RX_MUTE, 1'b1);
  endtask
  // hold the write until it is taken
  task wr(input logic [7:0] v);
    @(negedge MCLK) TX_WDATA = v;
    TX_WVALID = 1'b1;
    while (!TX_WREADY) @(negedge MCLK);
    @(negedge MCLK) TX_WVALID = 1'b0;
  endtask
  task give_verdict;
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (40000) @(posedge MCLK);
    errors++;
    give_verdict;
  end
  initial
  begin
    {NINE_BIT_SELECT, TX_ENABLE, RX_ENABLE, SEND_BREAK, WAKE_METHOD,
      RX_MUTE_SET, TX_EMPTY_INT_ENABLE, TX_DONE_INT_ENABLE, RX_INT_ENABLE,
      GLOBAL_INT_MASK, STATUS_ACCESS, DATA_READ, TX_WVALID, TX_NINTH_BIT,
      COARSE_DIVIDER_SEL, TX_RATE_SEL, TX_WDATA, RX_FINE_DIVIDER} = '0;
    RX_RATE_SEL = 3'h2;  // 64 clocks a bit, kept
    TX_FINE_DIVIDER = 8'h04;  // 64 clocks a bit
    IDLE_INT_ENABLE = 1'b1;
    SYS_RST = 1'b1;
    seed = 8'h05;
    repeat (4) @(negedge MCLK);
    SYS_RST = 1'b0;
    chk({SERIAL_OUT_PIN, TX_EMPTY_FLAG, IRQ}, 9'h006);
    RX_ENABLE = 1'b1;
    repeat (700) @(negedge MCLK);
    chk({IDLE_FLAG, IRQ}, 9'h003);
    IDLE_INT_ENABLE = 1'b0;
    clr;
    RX_INT_ENABLE = 1'b1;
    // both word sizes, one masked
    for (k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      NINE_BIT_SELECT = k[0];
      GLOBAL_INT_MASK = (k == 2);
      u_peer.send({k[1], seed}, 8 + k[0], 0);
      chk({k[0] & RX_NINTH_BIT, RX_DATA}, {k[0] & k[1], seed});
      chk({IRQ, RX_FULL_FLAG}, {k != 2, 1'b1});
      clr;
      flags(9'h000);
    end
    NINE_BIT_SELECT = 1'b0;
    u_peer.send({1'b0, seed}, 8, 1);
    chk(RX_DATA, seed);
    flags(9'h009);
    clr;
    u_peer.send(9'h000, 8, 1);
    flags(9'h009);
    clr;
    u_peer.send(9'h0C6, 8, 2);
    chk(RX_DATA, 8'hC6);
    flags(9'h00A);
    clr;
    // short start dropped, noise shows with next word
    u_peer.send(9'h000, 8, 3);
    flags(9'h000);
    u_peer.send(9'h03C, 8, 0);
    flags(9'h00A);
    clr;
    u_peer.send(9'h011, 8, 0);
    u_peer.send(9'h022, 8, 0);
    chk(RX_DATA, 8'h11);
    flags(9'h00C);
    clr;
    WAKE_METHOD = 1'b1;
    mute;
    u_peer.send(9'h055, 8, 0);
    chk({RX_MUTE, RX_FULL_FLAG}, 9'h002);
    u_peer.send(9'h0A5, 8, 0);
    chk({RX_MUTE, RX_FULL_FLAG, RX_DATA[0]}, 9'h003);
    clr;
    WAKE_METHOD = 1'b0;
    mute;
    repeat (700) @(negedge MCLK);
    chk({RX_MUTE, IDLE_FLAG}, 9'h000);
    // transmit: idle frame first
    TX_ENABLE = 1'b1;
    sa;
    wr(8'h5A);
    chk(TX_DONE_FLAG, 1'b0);
    for (n = 0; SERIAL_OUT_PIN && n < 2000; n++) @(negedge MCLK);
    chk(n >= 630 && n < 720, 1'b1);
    wr(8'h01);
    wr(8'h02);
    chk(TX_WREADY, 1'b0);
    TX_ENABLE = 1'b0;
    @(negedge MCLK) TX_ENABLE = 1'b1;
    wr(8'h3C);
    repeat (3000) @(negedge MCLK);
    chk(TX_EMPTY_FLAG, 1'b1);
    exq = '{9'h15A, 9'h13C};
    SEND_BREAK = 1'b1;
    repeat (1400) @(negedge MCLK);
    SEND_BREAK = 1'b0;
    wr(8'hE7);
    repeat (2000) @(negedge MCLK);
    foreach (exq[i]) chk(u_peer.got_q[i], exq[i]);
    chk(u_peer.got_q[2], 9'h000);
    chk(u_peer.got_q[$], 9'h1E7);
    give_verdict;
  end
endmodule
bind ast_top ast_chk u_chk (.*);
